/* File: rtl/rbs_pkg.sv */
// Shared constants and types of the inter-repeater backplane signalling block
package rbs_pkg;

  // System clock and backplane clock rates
  localparam int CLK_MHZ = 200;
  localparam int FAST_MHZ = 25;
  localparam int SLOW_MHZ = 10;
  localparam int FAST_HALF = CLK_MHZ / (2 * FAST_MHZ);
  localparam int SLOW_HALF = CLK_MHZ / (2 * SLOW_MHZ);

  // Divider layout
  localparam int FDIV_W = 3;
  localparam int SDIV_W = 5;
  localparam logic [FDIV_W-1:0] FDIV_FALL = FDIV_W'(FAST_HALF);
  localparam logic [FDIV_W-1:0] FDIV_LAST = FDIV_W'(2 * FAST_HALF - 1);
  localparam logic [SDIV_W-1:0] SDIV_HALF = SDIV_W'(SLOW_HALF);
  localparam logic [SDIV_W-1:0] SDIV_LAST = SDIV_W'(2 * SLOW_HALF - 1);

  // Data path sizes
  localparam int SYM_W = 5;
  localparam int FIFO_DEPTH = 32;
  localparam int PORTS = 8;

  // Collision force sense comparator codes
  localparam logic [1:0] CFS_NONE = 2'h3;
  localparam logic [1:0] CFS_MANY = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_DRIVE = 2'h2
  } rbs_link_st_type;

  // Link-side receive capture: two-entry ping-pong and its toggle
  typedef struct packed {
    logic [1:0][SYM_W-1:0] hold;
    logic wsel;
  } rbs_rx_link_type;

endpackage : rbs_pkg

/* File: rtl/rbs_stream_if.sv */
// Valid/ready stream between the block's own modules
`timescale 1ns/1ps
interface rbs_stream_if #(
  parameter int W = 5
);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : rbs_stream_if

/* File: rtl/rbs_fifo.sv */
// Synchronous FIFO with registered ready and valid flags
`timescale 1ns/1ps
module rbs_fifo
  import rbs_pkg::*;
#(
  parameter int W = SYM_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Streams
  rbs_stream_if.snk in_s,
  rbs_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic in_ready;
    logic out_valid;
  } rbs_fifo_st_type;

  rbs_fifo_st_type q;
  rbs_fifo_st_type d;
  logic [W-1:0] mem_q [DEPTH];
  logic push;
  logic pop;

  assign push = in_s.valid & q.in_ready;
  assign pop = q.out_valid & out_s.ready;
  assign in_s.ready = q.in_ready;
  assign out_s.valid = q.out_valid;
  assign out_s.data = mem_q[q.rd];

  always_comb begin
    d = q;
    if (push) begin
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
    d.in_ready = d.cnt != (AW+1)'(DEPTH);
    d.out_valid = d.cnt != '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{wr: '0, rd: '0, cnt: '0, in_ready: 1'b1, out_valid: 1'b0};
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[q.wr] <= in_s.data;
    end
  end

endmodule : rbs_fifo

/* File: rtl/rbs_backplane.sv */
// Inter-repeater backplane signalling for the 100 and 10 Mbps segments
// How it works
// RULE_01: Position-zero device pulls single-driver low while any local or board port receives.
// RULE_02: Position-zero device pulls multi-driver low while more than one port receives.
// RULE_03: Open-drain fast buffer direction is pulled low while this device drives.
// RULE_04: Fast valid is held low for the whole frame, framing clock and data.
// RULE_05: Five-bit symbols change on falling clock edge, sampled on rising edge.
// RULE_06: Fast clock is 25 MHz, driven only while this device carries a frame.
// RULE_07: Slow serial data is open-drain, driven and sampled on rising clock edges.
// RULE_08: Slow backplane clock is 10 MHz, driven only while transmitting.
// RULE_09: Slow clock output is released to high impedance while idle.
// RULE_10: Slow carrier enable is pulled low during carrier, released when idle.
// RULE_11: Slow carrier enable is open-drain so many devices share it.
// RULE_12: Open-drain slow buffer direction is pulled low while this device drives.
// RULE_13: Force sense: high none active, mid one, low more than one.
// RULE_14: Fast data and clock stay released unless this device is the driver.
`timescale 1ns/1ps
module rbs_backplane
  import rbs_pkg::*;
#(
  parameter int NPORTS = PORTS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Board strap and local port activity
  input wire logic board_position_select_i,
  input wire logic [NPORTS-1:0] fast_port_active_i,
  // Fast symbols to transmit
  input wire logic [SYM_W-1:0] fast_tx_symbol_i,
  input wire logic fast_tx_valid_i,
  output logic fast_tx_ready_o,
  // Fast symbols received
  output logic [SYM_W-1:0] fast_rx_symbol_o,
  output logic fast_rx_valid_o,
  // Slow serial transmit and receive
  input wire logic slow_tx_active_i,
  input wire logic slow_tx_bit_i,
  output logic slow_tx_taken_o,
  output logic slow_rx_bit_o,
  output logic slow_rx_valid_o,
  // Fast backplane pins
  input wire logic fast_backplane_clock_i,
  output logic fast_backplane_clock_o,
  output logic fast_backplane_clock_oe_o,
  input wire logic [SYM_W-1:0] fast_backplane_symbol_i,
  output logic [SYM_W-1:0] fast_backplane_symbol_o,
  output logic fast_backplane_symbol_oe_o,
  input wire logic fast_backplane_valid_n_i,
  output logic fast_backplane_valid_n_o,
  output logic fast_backplane_valid_n_oe_o,
  output logic fast_buffer_direction_o,
  output logic fast_buffer_direction_oe_o,
  output logic fast_single_driver_n_o,
  output logic fast_single_driver_n_oe_o,
  output logic fast_multi_driver_n_o,
  output logic fast_multi_driver_n_oe_o,
  input wire logic [1:0] fast_collision_force_sense_i,
  output logic fast_cfs_pull_mid_o,
  output logic fast_cfs_pull_low_o,
  // Slow backplane pins
  input wire logic slow_backplane_clock_i,
  output logic slow_backplane_clock_o,
  output logic slow_backplane_clock_oe_o,
  input wire logic slow_backplane_serial_data_i,
  output logic slow_backplane_serial_data_o,
  output logic slow_backplane_serial_data_oe_o,
  input wire logic slow_carrier_present_n_i,
  output logic slow_carrier_present_n_o,
  output logic slow_carrier_present_n_oe_o,
  output logic slow_buffer_direction_n_o,
  output logic slow_buffer_direction_n_oe_o
);

  typedef struct packed {
    rbs_link_st_type fst;
    rbs_link_st_type sst;
    logic [FDIV_W-1:0] fdiv;
    logic [SDIV_W-1:0] sdiv;
    logic fclk;
    logic fclk_oe;
    logic [SYM_W-1:0] fsym;
    logic fsym_oe;
    logic fvalid_oe;
    logic sclk;
    logic sclk_oe;
    logic sdat_oe;
    logic sena_oe;
    logic stx_taken;
    logic pos_s1;
    logic pos_s2;
    logic pos0;
    logic fvalid_s1;
    logic fvalid_s2;
    logic [1:0] cfs_s1;
    logic [1:0] cfs_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sdat_s1;
    logic sdat_s2;
    logic sena_s1;
    logic sena_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic rd_idx;
    logic single_oe;
    logic multi_oe;
    logic cfs_mid;
    logic cfs_low;
    logic [SYM_W-1:0] rx_sym;
    logic rx_valid;
    logic srx_bit;
    logic srx_valid;
    logic od_low;
  } rbs_state_type;

  rbs_state_type q;
  rbs_state_type d;
  rbs_rx_link_type lk_q = '0;
  rbs_rx_link_type lk_d;
  logic any_port;
  logic many_port;

  rbs_stream_if #(.W(SYM_W)) push_s ();
  rbs_stream_if #(.W(SYM_W)) pop_s ();

  assign push_s.data = fast_tx_symbol_i;
  assign push_s.valid = fast_tx_valid_i;
  assign fast_tx_ready_o = push_s.ready;

  rbs_fifo #(.W(SYM_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(push_s),
    .out_s(pop_s)
  );

  // Link domain: capture each framed symbol on the rising backplane clock
  always_comb begin
    lk_d = lk_q;
    if (!fast_backplane_valid_n_i) begin // RULE_04
      lk_d.hold[lk_q.wsel] = fast_backplane_symbol_i; // RULE_05
      lk_d.wsel = ~lk_q.wsel;
    end
  end

  always_ff @(posedge fast_backplane_clock_i) begin
    lk_q <= lk_d;
  end

  assign any_port = |fast_port_active_i;
  assign many_port = |(fast_port_active_i & (fast_port_active_i - NPORTS'(1)));
  assign pop_s.ready = (q.fst == ST_DRIVE) && (d.fdiv == FDIV_FALL);

  always_comb begin
    d = q;
    d.stx_taken = 1'b0;
    d.rx_valid = 1'b0;
    d.srx_valid = 1'b0;
    d.od_low = 1'b0;
    // Pin synchronisers
    d.pos_s1 = board_position_select_i;
    d.pos_s2 = q.pos_s1;
    d.pos0 = !q.pos_s2;
    d.fvalid_s1 = fast_backplane_valid_n_i;
    d.fvalid_s2 = q.fvalid_s1;
    d.cfs_s1 = fast_collision_force_sense_i;
    d.cfs_s2 = q.cfs_s1;
    d.scl_s1 = slow_backplane_clock_i;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sdat_s1 = slow_backplane_serial_data_i;
    d.sdat_s2 = q.sdat_s1;
    d.sena_s1 = slow_carrier_present_n_i;
    d.sena_s2 = q.sena_s1;
    d.tog_s1 = lk_q.wsel;
    d.tog_s2 = q.tog_s1;
    // Board activity and collision state
    d.single_oe = q.pos0 && (any_port || q.cfs_s2 != CFS_NONE); // RULE_01
    d.multi_oe = q.pos0 && (many_port || q.cfs_s2 == CFS_MANY); // RULE_02
    d.cfs_mid = any_port && !many_port; // RULE_13
    d.cfs_low = many_port; // RULE_13
    // Fast transmit: divider makes the clock, data moves on its falling edge
    case (q.fst)
      ST_IDLE: begin
        if (pop_s.valid && q.fvalid_s2) begin
          d.fst = ST_DRIVE;
          d.fdiv = '0;
          d.fclk = 1'b1;
          d.fclk_oe = 1'b1; // RULE_06
          d.fsym_oe = 1'b1;
          d.fvalid_oe = 1'b1; // RULE_04
        end
      end
      ST_DRIVE: begin
        d.fdiv = (q.fdiv == FDIV_LAST) ? '0 : q.fdiv + 1'b1;
        d.fclk = d.fdiv < FDIV_FALL; // RULE_06
        if (d.fdiv == FDIV_FALL) begin
          if (pop_s.valid) begin
            d.fsym = pop_s.data; // RULE_05
          end else begin
            d.fst = ST_IDLE;
            d.fclk_oe = 1'b0; // RULE_14
            d.fsym_oe = 1'b0; // RULE_14
            d.fvalid_oe = 1'b0;
          end
        end
      end
      default: begin
        d.fst = ST_IDLE;
      end
    endcase
    // Fast receive: event crossing by toggle, symbol read from the stable entry
    if (q.tog_s2 != q.tog_seen) begin
      d.tog_seen = q.tog_s2;
      d.rd_idx = ~q.rd_idx;
      d.rx_sym = lk_q.hold[q.rd_idx];
      d.rx_valid = q.fst == ST_IDLE; // RULE_14
    end
    // Slow transmit: bit driven at each rising clock edge
    case (q.sst)
      ST_IDLE: begin
        if (slow_tx_active_i && q.sena_s2) begin
          d.sst = ST_DRIVE;
          d.sdiv = '0;
          d.sclk = 1'b1;
          d.sclk_oe = 1'b1; // RULE_08
          d.sena_oe = 1'b1; // RULE_10
          d.sdat_oe = !slow_tx_bit_i; // RULE_07
          d.stx_taken = 1'b1;
        end
      end
      ST_DRIVE: begin
        d.sdiv = (q.sdiv == SDIV_LAST) ? '0 : q.sdiv + 1'b1;
        d.sclk = d.sdiv < SDIV_HALF; // RULE_08
        if (d.sdiv == '0) begin
          if (slow_tx_active_i) begin
            d.sdat_oe = !slow_tx_bit_i; // RULE_07
            d.stx_taken = 1'b1;
          end else begin
            d.sst = ST_IDLE;
            d.sclk = 1'b0;
            d.sclk_oe = 1'b0; // RULE_09
            d.sena_oe = 1'b0; // RULE_10
            d.sdat_oe = 1'b0;
          end
        end
      end
      default: begin
        d.sst = ST_IDLE;
      end
    endcase
    // Slow receive: sample data on rising clock while carrier is present
    if (q.scl_s2 && !q.scl_s3 && !q.sena_s2 && q.sst == ST_IDLE) begin // RULE_07
      d.srx_bit = q.sdat_s2;
      d.srx_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.fst <= ST_IDLE;
      q.sst <= ST_IDLE;
      q.fvalid_s1 <= 1'b1;
      q.fvalid_s2 <= 1'b1;
      q.sena_s1 <= 1'b1;
      q.sena_s2 <= 1'b1;
      q.cfs_s1 <= CFS_NONE;
      q.cfs_s2 <= CFS_NONE;
      q.tog_s1 <= d.tog_s1;
      q.tog_s2 <= d.tog_s2;
      q.tog_seen <= q.tog_s2;
      q.rd_idx <= q.tog_s2;
    end else begin
      q <= d;
    end
  end

  // Open-drain pins only ever pull low
  assign fast_backplane_clock_o = q.fclk;
  assign fast_backplane_clock_oe_o = q.fclk_oe;
  assign fast_backplane_symbol_o = q.fsym;
  assign fast_backplane_symbol_oe_o = q.fsym_oe;
  assign fast_backplane_valid_n_o = q.od_low;
  assign fast_backplane_valid_n_oe_o = q.fvalid_oe;
  assign fast_buffer_direction_o = q.od_low;
  assign fast_buffer_direction_oe_o = q.fvalid_oe; // RULE_03
  assign fast_single_driver_n_o = q.od_low;
  assign fast_single_driver_n_oe_o = q.single_oe;
  assign fast_multi_driver_n_o = q.od_low;
  assign fast_multi_driver_n_oe_o = q.multi_oe;
  assign fast_cfs_pull_mid_o = q.cfs_mid;
  assign fast_cfs_pull_low_o = q.cfs_low;
  assign fast_rx_symbol_o = q.rx_sym;
  assign fast_rx_valid_o = q.rx_valid;
  assign slow_backplane_clock_o = q.sclk;
  assign slow_backplane_clock_oe_o = q.sclk_oe;
  assign slow_backplane_serial_data_o = q.od_low;
  assign slow_backplane_serial_data_oe_o = q.sdat_oe;
  assign slow_carrier_present_n_o = q.od_low;
  assign slow_carrier_present_n_oe_o = q.sena_oe; // RULE_11
  assign slow_buffer_direction_n_o = q.od_low;
  assign slow_buffer_direction_n_oe_o = q.sena_oe; // RULE_12
  assign slow_tx_taken_o = q.stx_taken;
  assign slow_rx_bit_o = q.srx_bit;
  assign slow_rx_valid_o = q.srx_valid;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_single_follows_ports: assert property ( // RULE_01
    q.pos0 && any_port |=> fast_single_driver_n_oe_o)
    else $error("single driver not asserted for active port");
  a_multi_needs_two: assert property ( // RULE_02
    fast_multi_driver_n_oe_o
      |-> $past(q.pos0) && ($past(many_port) || $past(q.cfs_s2) == CFS_MANY))
    else $error("multi driver asserted without collision");
  a_fast_dir_owner: assert property ( // RULE_03
    $rose(fast_backplane_clock_oe_o) |-> fast_buffer_direction_oe_o && fast_backplane_valid_n_oe_o)
    else $error("buffer direction not turned with frame start");
  a_valid_frames_clk: assert property ( // RULE_04
    $fell(fast_backplane_valid_n_oe_o) |-> !fast_backplane_clock_o && $past(fast_backplane_clock_o, 4))
    else $error("frame did not end on a falling clock");
  a_data_on_fall: assert property ( // RULE_05
    fast_backplane_symbol_oe_o && $changed(fast_backplane_symbol_o) |-> $fell(fast_backplane_clock_o))
    else $error("symbol changed outside a falling edge");
  a_fast_clk_period: assert property ( // RULE_06
    $rose(fast_backplane_clock_o) |-> fast_backplane_clock_o[*4] ##1 !fast_backplane_clock_o)
    else $error("fast clock high phase is not four cycles");
  a_slow_data_rise: assert property ( // RULE_07
    slow_carrier_present_n_oe_o && $changed(slow_backplane_serial_data_oe_o)
      |-> $rose(slow_backplane_clock_o))
    else $error("slow data changed outside a rising edge");
  a_slow_clk_idle: assert property ( // RULE_09
    !slow_carrier_present_n_oe_o |-> !slow_backplane_clock_oe_o)
    else $error("slow clock driven while idle");
  a_slow_enable_start: assert property ( // RULE_10
    slow_tx_active_i && q.sena_s2 && q.sst == ST_IDLE
      |=> slow_carrier_present_n_oe_o && slow_tx_taken_o)
    else $error("carrier enable not pulled at start");
  a_slow_dir_enable: assert property ( // RULE_12
    slow_buffer_direction_n_oe_o == slow_carrier_present_n_oe_o)
    else $error("slow direction disagrees with carrier");
  a_fast_quiet: assert property ( // RULE_14
    !fast_backplane_valid_n_oe_o |-> !fast_backplane_symbol_oe_o && !fast_backplane_clock_oe_o)
    else $error("fast pins driven outside own frame");

  c_fast_frame: cover property (
    $rose(fast_backplane_valid_n_oe_o) ##[1:200] $fell(fast_backplane_valid_n_oe_o));
  c_multi_driver: cover property ($rose(fast_multi_driver_n_oe_o));
  c_slow_frame: cover property ($rose(slow_carrier_present_n_oe_o) ##[1:400] slow_tx_taken_o);
  c_rx_symbol: cover property (fast_rx_valid_o);

endmodule : rbs_backplane

/* File: sim/rbs_peer.sv */
// Behavioural peer repeater driving the fast and slow backplanes
`timescale 1ns/1ps
module rbs_peer (
  // Resolved shared lines
  input wire logic fval_w_i,
  input wire logic scar_w_i,
  // Fast backplane drive
  output logic fclk_o,
  output logic fclk_oe_o,
  output logic [4:0] fsym_o,
  output logic fsym_oe_o,
  output logic fval_low_o,
  // Slow backplane drive
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic sdat_low_o,
  output logic scar_low_o
);
  initial begin
    fclk_o = 1'b1;
    fclk_oe_o = 1'b0;
    fsym_o = 5'h00;
    fsym_oe_o = 1'b0;
    fval_low_o = 1'b0;
    sclk_o = 1'b0;
    sclk_oe_o = 1'b0;
    sdat_low_o = 1'b0;
    scar_low_o = 1'b0;
  end

  // Frame of n symbols on a 15 ns link clock, started only on an idle line
  task automatic send_fast(input int n);
    wait (fval_w_i === 1'b1);
    fval_low_o = 1'b1;
    fclk_oe_o = 1'b1;
    #15;
    for (int k = 0; k < n; k++) begin
      fclk_o = 1'b0;
      fsym_o = 5'(k * 3 + 1);
      fsym_oe_o = 1'b1;
      #7.5;
      fclk_o = 1'b1;
      #7.5;
    end
    fclk_oe_o = 1'b0;
    fsym_oe_o = 1'b0;
    fval_low_o = 1'b0;
  endtask : send_fast

  // Eight serial bits, LSB first, data moved shortly after each rising edge
  task automatic send_slow(input logic [7:0] bits);
    wait (scar_w_i === 1'b1);
    scar_low_o = 1'b1;
    sclk_oe_o = 1'b1;
    for (int k = 0; k < 8; k++) begin
      #10;
      sdat_low_o = ~bits[k];
      #40;
      sclk_o = 1'b0;
      #50;
      sclk_o = 1'b1;
    end
    #50;
    sclk_o = 1'b0;
    sclk_oe_o = 1'b0;
    scar_low_o = 1'b0;
    sdat_low_o = 1'b0;
  endtask : send_slow
endmodule : rbs_peer

/* File: sim/rbs_backplane_bench.sv */
// Self-checking bench of the backplane signalling block
`timescale 1ns/1ps
`define RBS_CHECK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module rbs_backplane_bench;
  import rbs_pkg::*;
  logic clk_i, rst_i, board_position_select_i, fast_tx_valid_i, slow_tx_active_i, slow_tx_bit_i;
  logic [7:0] fast_port_active_i;
  logic [4:0] fast_tx_symbol_i, fast_rx_symbol_o, fast_backplane_symbol_i, fast_backplane_symbol_o;
  logic [4:0] p_fsym;
  logic [1:0] fast_collision_force_sense_i;
  logic fast_tx_ready_o, fast_rx_valid_o, slow_tx_taken_o, slow_rx_bit_o, slow_rx_valid_o;
  logic fast_backplane_clock_i, fast_backplane_clock_o, fast_backplane_clock_oe_o;
  logic fast_backplane_symbol_oe_o, fast_backplane_valid_n_i, fast_backplane_valid_n_o;
  logic fast_backplane_valid_n_oe_o, fast_buffer_direction_o, fast_buffer_direction_oe_o;
  logic fast_single_driver_n_o, fast_single_driver_n_oe_o, fast_multi_driver_n_o;
  logic fast_multi_driver_n_oe_o, fast_cfs_pull_mid_o, fast_cfs_pull_low_o;
  logic slow_backplane_clock_i, slow_backplane_clock_o, slow_backplane_clock_oe_o;
  logic slow_backplane_serial_data_i, slow_backplane_serial_data_o;
  logic slow_backplane_serial_data_oe_o, slow_carrier_present_n_i, slow_carrier_present_n_o;
  logic slow_carrier_present_n_oe_o, slow_buffer_direction_n_o, slow_buffer_direction_n_oe_o;
  logic p_fclk, p_fclk_oe, p_fsym_oe, p_fval_low, p_sclk, p_sclk_oe, p_sdat_low, p_scar_low;
  logic early;
  logic [4:0] ftx_q[$], frx_q[$];
  logic stx_q[$], srx_q[$];
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int taken_n = 0;
  time ft = 0;
  time st = 0;

  // Wire levels: pull-ups on fast lines and slow data/carrier, pull-down on slow clock
  // Fast clock pull-up settles late, so a released clock rises after valid is gone
  assign #1 fast_backplane_clock_i = fast_backplane_clock_oe_o ? fast_backplane_clock_o :
                                  (p_fclk_oe ? p_fclk : 1'b1);
  assign fast_backplane_symbol_i = fast_backplane_symbol_oe_o ? fast_backplane_symbol_o :
                                   (p_fsym_oe ? p_fsym : 5'h1F);
  assign fast_backplane_valid_n_i = !((fast_backplane_valid_n_oe_o && !fast_backplane_valid_n_o)
                                      || p_fval_low);
  assign slow_backplane_clock_i = slow_backplane_clock_oe_o ? slow_backplane_clock_o :
                                  (p_sclk_oe ? p_sclk : 1'b0);
  assign slow_backplane_serial_data_i = !((slow_backplane_serial_data_oe_o &&
                                           !slow_backplane_serial_data_o) || p_sdat_low);
  assign slow_carrier_present_n_i = !((slow_carrier_present_n_oe_o && !slow_carrier_present_n_o)
                                      || p_scar_low);

  rbs_backplane dut (
    .clk_i, .rst_i, .board_position_select_i, .fast_port_active_i, .fast_tx_symbol_i,
    .fast_tx_valid_i, .fast_tx_ready_o, .fast_rx_symbol_o, .fast_rx_valid_o, .slow_tx_active_i,
    .slow_tx_bit_i, .slow_tx_taken_o, .slow_rx_bit_o, .slow_rx_valid_o, .fast_backplane_clock_i,
    .fast_backplane_clock_o, .fast_backplane_clock_oe_o, .fast_backplane_symbol_i,
    .fast_backplane_symbol_o, .fast_backplane_symbol_oe_o, .fast_backplane_valid_n_i,
    .fast_backplane_valid_n_o, .fast_backplane_valid_n_oe_o, .fast_buffer_direction_o,
    .fast_buffer_direction_oe_o, .fast_single_driver_n_o, .fast_single_driver_n_oe_o,
    .fast_multi_driver_n_o, .fast_multi_driver_n_oe_o, .fast_collision_force_sense_i,
    .fast_cfs_pull_mid_o, .fast_cfs_pull_low_o, .slow_backplane_clock_i, .slow_backplane_clock_o,
    .slow_backplane_clock_oe_o, .slow_backplane_serial_data_i, .slow_backplane_serial_data_o,
    .slow_backplane_serial_data_oe_o, .slow_carrier_present_n_i, .slow_carrier_present_n_o,
    .slow_carrier_present_n_oe_o, .slow_buffer_direction_n_o, .slow_buffer_direction_n_oe_o
  );

  rbs_peer peer (
    .fval_w_i(fast_backplane_valid_n_i), .scar_w_i(slow_carrier_present_n_i),
    .fclk_o(p_fclk), .fclk_oe_o(p_fclk_oe), .fsym_o(p_fsym), .fsym_oe_o(p_fsym_oe),
    .fval_low_o(p_fval_low), .sclk_o(p_sclk), .sclk_oe_o(p_sclk_oe), .sdat_low_o(p_sdat_low),
    .scar_low_o(p_scar_low)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Symbols this device puts on the fast wire, taken at the wire's rising edge
  always @(posedge fast_backplane_clock_i) begin
    if (fast_backplane_valid_n_oe_o === 1'b1) begin
      ftx_q.push_back(fast_backplane_symbol_i);
      `RBS_CHECK({fast_buffer_direction_oe_o, fast_buffer_direction_o}, 2'h2)
      if (ft != 0) `RBS_CHECK($time - ft, 64'd40)
      ft = $time;
    end
  end

  // Serial bits this device sends, taken mid-bit
  always @(negedge slow_backplane_clock_i) begin
    if (slow_carrier_present_n_oe_o === 1'b1) begin
      stx_q.push_back(slow_backplane_serial_data_i);
      `RBS_CHECK({slow_buffer_direction_n_oe_o, slow_carrier_present_n_i}, 2'h2)
      if (st != 0) `RBS_CHECK($time - st, 64'd100)
      st = $time;
    end
  end

  always @(posedge clk_i) begin
    if (fast_rx_valid_o === 1'b1) frx_q.push_back(fast_rx_symbol_o);
    if (slow_rx_valid_o === 1'b1) srx_q.push_back(slow_rx_bit_o);
    if (slow_tx_taken_o === 1'b1) taken_n++;
    if (fast_backplane_symbol_oe_o === 1'b1 && p_fval_low) early = 1'b1;
    cycles++;
    if (cycles == 6000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic reset_test;
    @(posedge clk_i);
    `RBS_CHECK({fast_backplane_clock_oe_o, slow_backplane_clock_oe_o, fast_tx_ready_o}, 3'h1)
  endtask : reset_test

  // Fields: position, port activity, sense code, then single/multi/mid/low expected
  task automatic board_test;
    logic [14:0] tab [7] = '{15'h0030, 15'h013A, 15'h207D, 15'h6071, 15'h000C, 15'h0018, 15'h0028};
    logic [3:0] got;
    for (int i = 0; i < 7; i++) begin
      board_position_select_i <= tab[i][14];
      fast_port_active_i <= tab[i][13:6];
      fast_collision_force_sense_i <= tab[i][5:4];
      repeat (6) @(posedge clk_i);
      got = {fast_single_driver_n_oe_o, fast_multi_driver_n_oe_o, fast_cfs_pull_mid_o,
             fast_cfs_pull_low_o};
      `RBS_CHECK(got, tab[i][3:0])
    end
    board_position_select_i <= 1'b0;
    fast_port_active_i <= 8'h00;
    fast_collision_force_sense_i <= CFS_NONE;
    @(posedge clk_i);
  endtask : board_test

  // FIFO fills while a peer holds the fast line, then drains as one frame
  task automatic fast_test;
    int n;
    logic [2:0] tail;
    early = 1'b0;
    n = 0;
    fork
      peer.send_fast(40);
      begin
        repeat (6) @(posedge clk_i);
        fast_tx_valid_i <= 1'b1;
        fast_tx_symbol_i <= 5'h02;
        do begin
          @(posedge clk_i);
          if (fast_tx_ready_o === 1'b1) n++;
          fast_tx_symbol_i <= 5'(n * 5 + 2);
        end while (fast_tx_ready_o === 1'b1);
        fast_tx_valid_i <= 1'b0;
      end
    join
    `RBS_CHECK(n, FIFO_DEPTH)
    `RBS_CHECK(early, 1'b0)
    n = 0;
    while ((ftx_q.size() < 32 || fast_backplane_valid_n_oe_o !== 1'b0) && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    `RBS_CHECK(ftx_q.size(), 32)
    for (int i = 0; i < 32; i++) `RBS_CHECK(ftx_q[i], 5'(i * 5 + 2))
    `RBS_CHECK(frx_q.size(), 40)
    for (int i = 0; i < 40; i++) `RBS_CHECK(frx_q[i], 5'(i * 3 + 1))
    tail = {fast_backplane_clock_oe_o, fast_backplane_symbol_oe_o, fast_buffer_direction_oe_o};
    `RBS_CHECK(tail, 3'h0)
  endtask : fast_test

  task automatic wait_taken;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (slow_tx_taken_o !== 1'b1 && n < 60);
    `RBS_CHECK(n < 60, 1'b1)
  endtask : wait_taken

  // Peer frame holds off our start; then eight bits go out
  task automatic slow_test;
    logic [7:0] pat;
    logic [7:0] prx;
    logic [2:0] tail;
    pat = 8'hB4;
    prx = 8'h6D;
    slow_tx_bit_i <= pat[0];
    fork
      peer.send_slow(prx);
      begin
        repeat (30) @(posedge clk_i);
        slow_tx_active_i <= 1'b1;
      end
    join
    `RBS_CHECK(taken_n, 0)
    for (int k = 1; k <= 8; k++) begin
      wait_taken();
      if (k < 8) slow_tx_bit_i <= pat[k];
      else slow_tx_active_i <= 1'b0;
    end
    repeat (40) @(posedge clk_i);
    `RBS_CHECK(stx_q.size(), 8)
    for (int k = 0; k < 8; k++) `RBS_CHECK(stx_q[k], pat[k])
    `RBS_CHECK(srx_q.size(), 8)
    for (int k = 0; k < 8; k++) `RBS_CHECK(srx_q[k], prx[k])
    tail = {slow_backplane_clock_oe_o, slow_backplane_clock_i, slow_carrier_present_n_oe_o};
    `RBS_CHECK(tail, 3'h0)
  endtask : slow_test

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst_i = 1'b1;
    board_position_select_i = 1'b0;
    fast_port_active_i = 8'h00;
    fast_tx_symbol_i = 5'h00;
    fast_tx_valid_i = 1'b0;
    slow_tx_active_i = 1'b0;
    slow_tx_bit_i = 1'b0;
    fast_collision_force_sense_i = CFS_NONE;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_test();
    board_test();
    fast_test();
    slow_test();
    report_and_stop();
  end
endmodule : rbs_backplane_bench
